// File: src/spmc_top.sv
`timescale 1ns/1ps
`default_nettype none

module spmc_fifo #(
    parameter int W     = 8,
    parameter int DEPTH = 4
) (
    input  wire logic         clk,       // Core clock
    input  wire logic         nrst,      // Async reset, active low
    input  wire logic         in_valid,  // Write request
    output logic              in_ready,  // Not full
    input  wire logic [W-1:0] in_data,   // Write data
    output logic              out_valid, // Not empty
    input  wire logic         out_ready, // Read accept
    output logic [W-1:0]      out_data   // Head word
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW:0]  wr_ptr_r;
    logic [AW:0]  rd_ptr_r;
    logic         push;
    logic         pop;

    // Extra pointer bit tells full from empty
    assign in_ready  = (wr_ptr_r[AW] == rd_ptr_r[AW]) || (wr_ptr_r[AW-1:0] != rd_ptr_r[AW-1:0]);
    assign out_valid = (wr_ptr_r != rd_ptr_r);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr_r[AW-1:0]];

    // Storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end
endmodule

module spmc_top #(
    parameter int BULK_CYC = spmc_pkg::BULK_ERASE_CYC
) (
    input  wire logic                   clk,                          // 250 MHz core clock
    input  wire logic                   nrst,                         // Async reset, active low
    input  wire logic                   master_clear_program_pin,     // High at entry level
    input  wire logic                   alternate_program_enable_pin, // High at entry level
    input  wire logic                   serial_prog_clock,            // Default serial clock
    input  wire logic                   serial_prog_data_pin,         // Default data in
    output logic                        serial_prog_data_out,         // Default data out
    output logic                        serial_prog_data_oe,          // Default data drive
    input  wire logic                   alternate_serial_clock_pin,   // Dedicated clock
    input  wire logic                   alternate_serial_data_pin,    // Dedicated data in
    output logic                        alternate_serial_data_out,    // Dedicated data out
    output logic                        alternate_serial_data_oe,     // Dedicated data drive
    input  wire logic                   low_voltage_request_pin,      // Low-voltage entry
    input  wire logic                   low_voltage_programming_option, // Config bit
    input  wire logic                   alternate_port_enable,        // Config bit
    input  wire logic [1:0]             boot_region_size_field,       // Boot size config
    input  wire logic                   boot_protect,                 // Boot region locked
    input  wire logic [5:0]             block_protect,                // Per-block lock
    input  wire logic [21:0]            table_pointer,                // Target address
    input  wire logic                   ctl_wr_en,                    // Control reg write
    input  wire logic [7:0]             ctl_wr_data,                  // Control reg data
    output logic [7:0]                  ctl_rd_data,                  // Control reg value
    input  wire logic                   bulk_erase_req,               // Bulk erase request
    output logic                        prog_mode,                    // In program/verify
    output logic                        unused_io_hiz,                // Float unused I/O
    output logic                        alt_port_active,              // Dedicated port owns
    output logic                        cfg_port_bit_wr_allow,        // Alt bit writable
    output logic                        keep_alt_port_bit,            // Shield alt bit
    output logic                        nvm_active,                   // Array operation on
    output logic                        nvm_erase,                    // Operation is erase
    output logic                        nvm_bulk,                     // Operation is bulk
    output logic                        nvm_done,                     // Operation finished
    output logic                        serial_rx_ready,              // FIFO has room
    output logic                        word_valid,                   // Received word ready
    input  wire logic                   word_ready,                   // Core takes word
    output spmc_pkg::spmc_word_s        word_data                     // Received word
);
    logic [6:0]             pin_s1_r;
    logic [6:0]             pin_s2_r;
    logic                   clk_prev_r;
    logic                   def_hv;
    logic                   def_clk;
    logic                   def_dat;
    logic                   alt_hv;
    logic                   alt_clk;
    logic                   alt_dat;
    logic                   def_en;
    logic                   alt_en;
    logic                   sel_clk;
    logic                   sel_dat;
    logic                   clk_rise;
    logic                   clk_fall;
    spmc_pkg::spmc_port_e   port_r;
    spmc_pkg::spmc_seq_e    seq_r;
    logic [4:0]             bit_cnt_r;
    logic [spmc_pkg::WORD_W-1:0] shift_r;
    logic [spmc_pkg::WORD_W-1:0] word_nxt;
    logic                   word_push;
    logic                   start_word;
    logic [7:0]             ctl_r;
    logic [7:0]             ctl_nxt;
    logic                   trig_req;
    logic                   op_ok;
    logic                   op_start;
    logic                   refuse_ev;
    logic                   rgn_boot;
    logic [2:0]             rgn_block;
    logic                   rgn_locked;
    logic                   bulk_r;
    logic [spmc_pkg::BULK_TMR_W-1:0] tmr_r;
    logic                   done_r;

    // Boot limit for a size field; wider boot pushes block 0 start up
    function automatic logic [21:0] boot_limit(input logic [1:0] sz);
        case (sz)
            2'h0:    boot_limit = spmc_pkg::BOOT_LIM_1KW;
            2'h1:    boot_limit = spmc_pkg::BOOT_LIM_2KW;
            default: boot_limit = spmc_pkg::BOOT_LIM_4KW;
        endcase
    endfunction

    // Pin synchronisers; stage one feeds stage two only
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
        end else begin
            pin_s1_r <= {master_clear_program_pin, serial_prog_clock, serial_prog_data_pin,
                         alternate_program_enable_pin, alternate_serial_clock_pin,
                         alternate_serial_data_pin, low_voltage_request_pin};
            pin_s2_r <= pin_s1_r;
        end
    end

    assign {def_hv, def_clk, def_dat, alt_hv, alt_clk, alt_dat} = pin_s2_r[6:1];
    // Low-voltage request only honoured with the option fuse set
    assign def_en = def_hv || (low_voltage_programming_option && pin_s2_r[0]);
    assign alt_en = alt_hv && alternate_port_enable;

    // Port ownership: first enable wins, held until it drops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            port_r <= spmc_pkg::PORT_NONE;
        end else begin
            case (port_r)
                spmc_pkg::PORT_NONE: begin
                    // Entry needs clock and data low on the claiming port
                    if (def_en && !def_clk && !def_dat) begin
                        port_r <= spmc_pkg::PORT_DEF;
                    end else if (alt_en && !alt_clk && !alt_dat) begin
                        port_r <= spmc_pkg::PORT_ALT;
                    end
                end
                spmc_pkg::PORT_DEF: begin
                    if (!def_en) begin
                        port_r <= spmc_pkg::PORT_NONE;
                    end
                end
                spmc_pkg::PORT_ALT: begin
                    if (!alt_en) begin
                        port_r <= spmc_pkg::PORT_NONE;
                    end
                end
                default: port_r <= spmc_pkg::PORT_NONE;
            endcase
        end
    end

    assign prog_mode             = (port_r != spmc_pkg::PORT_NONE);
    assign unused_io_hiz         = prog_mode;
    assign alt_port_active       = (port_r == spmc_pkg::PORT_ALT);
    assign cfg_port_bit_wr_allow = (port_r == spmc_pkg::PORT_DEF);
    assign keep_alt_port_bit     = nvm_bulk && alt_port_active;
    // Readback lives in another block; data pins never driven here
    assign serial_prog_data_out      = 1'b0;
    assign serial_prog_data_oe       = 1'b0;
    assign alternate_serial_data_out = 1'b0;
    assign alternate_serial_data_oe  = 1'b0;

    // Selected port's clock and data; the other port is ignored
    assign sel_clk  = alt_port_active ? alt_clk : def_clk;
    assign sel_dat  = alt_port_active ? alt_dat : def_dat;
    assign clk_rise = prog_mode && sel_clk && !clk_prev_r;
    assign clk_fall = prog_mode && !sel_clk && clk_prev_r;

    // Link clock edge finder
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            clk_prev_r <= 1'b0;
        end else begin
            clk_prev_r <= sel_clk;
        end
    end

    // Shift on falling edge, LSB first; frozen while bulk erase runs
    assign word_nxt   = {sel_dat, shift_r[spmc_pkg::WORD_W-1:1]};
    assign word_push  = clk_fall && (seq_r != spmc_pkg::SQ_TIMED)
                        && (bit_cnt_r == spmc_pkg::LAST_BIT);
    assign start_word = word_push && (word_nxt[3:0] == spmc_pkg::CMD_START);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            shift_r   <= '0;
            bit_cnt_r <= '0;
        end else if (!prog_mode) begin
            bit_cnt_r <= '0;
        end else if (clk_fall && seq_r != spmc_pkg::SQ_TIMED) begin
            shift_r   <= word_nxt;
            bit_cnt_r <= (bit_cnt_r == spmc_pkg::LAST_BIT) ? 5'h00 : bit_cnt_r + 5'h01;
        end
    end

    // Words go to the core; a full FIFO drops the word
    spmc_fifo #(
        .W     (spmc_pkg::WORD_W),
        .DEPTH (spmc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .in_valid  (word_push),
        .in_ready  (serial_rx_ready),
        .in_data   (word_nxt),
        .out_valid (word_valid),
        .out_ready (word_ready),
        .out_data  (word_data)
    );

    // Region decode: boot below limit, else 16-Kbyte block index
    assign rgn_boot   = (table_pointer < boot_limit(boot_region_size_field));
    assign rgn_block  = table_pointer[spmc_pkg::BLOCK_SHIFT+2:spmc_pkg::BLOCK_SHIFT];
    assign rgn_locked = rgn_boot ? boot_protect
                      : (rgn_block < 3'(spmc_pkg::NUM_BLOCKS)) ? block_protect[rgn_block]
                      : 1'b1;

    // Trigger acceptance checks use the register as it stood before
    assign trig_req  = prog_mode && (seq_r == spmc_pkg::SQ_IDLE)
                       && ((ctl_wr_en && ctl_wr_data[spmc_pkg::CTL_TRIGGER]) || start_word);
    assign op_ok     = ctl_r[spmc_pkg::CTL_MODIFY_EN]
                       && ctl_r[spmc_pkg::CTL_PGM_SPACE] && !ctl_r[spmc_pkg::CTL_CFG_SPACE]
                       && !rgn_locked;
    assign op_start  = trig_req && op_ok;
    assign refuse_ev = trig_req && !op_ok;

    // Control register next value; hardware sets beat clears
    always_comb begin
        ctl_nxt = ctl_r;
        if (ctl_wr_en) begin
            ctl_nxt = ctl_wr_data;
            ctl_nxt[spmc_pkg::CTL_TRIGGER] = ctl_r[spmc_pkg::CTL_TRIGGER];
        end
        // A new trigger in the done cycle must not be wiped by the clear
        if (done_r) begin
            ctl_nxt[spmc_pkg::CTL_TRIGGER] = 1'b0;
        end
        if (op_start) begin
            ctl_nxt[spmc_pkg::CTL_TRIGGER] = 1'b1;
        end
        if (refuse_ev) begin
            ctl_nxt[spmc_pkg::CTL_REFUSED] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctl_r <= spmc_pkg::CTL_RESET;
        end else begin
            ctl_r <= ctl_nxt;
        end
    end

    assign ctl_rd_data = ctl_r;

    // Sequencer: arm, then act on the 4th clock of the next command
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            seq_r  <= spmc_pkg::SQ_IDLE;
            bulk_r <= 1'b0;
            tmr_r  <= '0;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (!prog_mode) begin
                seq_r  <= spmc_pkg::SQ_IDLE;
                bulk_r <= 1'b0;
            end else begin
                case (seq_r)
                    spmc_pkg::SQ_IDLE: begin
                        if (op_start) begin
                            seq_r  <= spmc_pkg::SQ_ARMED;
                            bulk_r <= 1'b0;
                        end else if (bulk_erase_req) begin
                            seq_r  <= spmc_pkg::SQ_ARMED;
                            bulk_r <= 1'b1;
                        end
                    end
                    spmc_pkg::SQ_ARMED: begin
                        if (bulk_r && clk_fall && bit_cnt_r == spmc_pkg::HOLD_BIT) begin
                            seq_r <= spmc_pkg::SQ_TIMED;
                            tmr_r <= spmc_pkg::BULK_TMR_W'(BULK_CYC - 1);
                        end else if (!bulk_r && clk_rise
                                     && bit_cnt_r == spmc_pkg::HOLD_BIT) begin
                            seq_r <= spmc_pkg::SQ_HOLD;
                        end
                    end
                    spmc_pkg::SQ_HOLD: begin
                        if (clk_fall) begin
                            seq_r  <= spmc_pkg::SQ_IDLE;
                            done_r <= 1'b1;
                        end
                    end
                    spmc_pkg::SQ_TIMED: begin
                        if (tmr_r == '0) begin
                            seq_r  <= spmc_pkg::SQ_IDLE;
                            bulk_r <= 1'b0;
                            done_r <= 1'b1;
                        end else begin
                            tmr_r <= tmr_r - 1'b1;
                        end
                    end
                    default: seq_r <= spmc_pkg::SQ_IDLE;
                endcase
            end
        end
    end

    // Active and bulk gated by mode so an aborted operation drops with the enable pin
    assign nvm_active = prog_mode
                        && ((seq_r == spmc_pkg::SQ_HOLD) || (seq_r == spmc_pkg::SQ_TIMED));
    assign nvm_bulk   = prog_mode && (seq_r == spmc_pkg::SQ_TIMED);
    assign nvm_erase  = nvm_bulk || ctl_r[spmc_pkg::CTL_ERASE_SEL];
    assign nvm_done   = done_r;

    // Checks
    refuse_modify_enable_a: assert property (
        @(posedge clk) disable iff (!nrst)
        trig_req && !ctl_r[spmc_pkg::CTL_MODIFY_EN]
        |=> ctl_r[spmc_pkg::CTL_REFUSED] && seq_r == spmc_pkg::SQ_IDLE)
        else $error("trigger accepted without modify enable");

    arm_target_a: assert property (
        @(posedge clk) disable iff (!nrst)
        seq_r == spmc_pkg::SQ_HOLD
        |-> ctl_r[spmc_pkg::CTL_PGM_SPACE] && !ctl_r[spmc_pkg::CTL_CFG_SPACE])
        else $error("row operation without code memory target");

    trigger_arms_a: assert property (
        @(posedge clk) disable iff (!nrst)
        op_start |=> seq_r == spmc_pkg::SQ_ARMED && ctl_r[spmc_pkg::CTL_TRIGGER])
        else $error("trigger did not arm the sequencer");

    hold_fall_a: assert property (
        @(posedge clk) disable iff (!nrst)
        seq_r == spmc_pkg::SQ_HOLD && clk_fall && prog_mode
        |=> seq_r == spmc_pkg::SQ_IDLE && nvm_done ##1 !ctl_r[spmc_pkg::CTL_TRIGGER])
        else $error("row operation did not end on clock fall");

    bulk_start_a: assert property (
        @(posedge clk) disable iff (!nrst)
        seq_r == spmc_pkg::SQ_ARMED && bulk_r && clk_fall && bit_cnt_r == 5'h03 && prog_mode
        |=> (nvm_bulk && nvm_erase) [*2])
        else $error("bulk erase did not start on fourth fall");

    erase_sel_a: assert property (
        @(posedge clk) disable iff (!nrst)
        $rose(nvm_active) && !nvm_bulk |-> nvm_erase == $past(ctl_r[spmc_pkg::CTL_ERASE_SEL]))
        else $error("erase select not honoured");

    boot_4k_a: assert property (
        @(posedge clk) disable iff (!nrst)
        boot_region_size_field == 2'h2 |-> rgn_boot == (table_pointer <= 22'h001FFF))
        else $error("four kiloword boot limit wrong");

    port_lock_a: assert property (
        @(posedge clk) disable iff (!nrst)
        port_r == spmc_pkg::PORT_DEF && def_en |=> port_r == spmc_pkg::PORT_DEF)
        else $error("default port lost ownership");

    alt_needs_cfg_a: assert property (
        @(posedge clk) disable iff (!nrst)
        $rose(alt_port_active) |-> $past(alternate_port_enable) && $past(alt_hv))
        else $error("dedicated port taken without enable bit");

    mode_exit_a: assert property (
        @(posedge clk) disable iff (!nrst)
        port_r == spmc_pkg::PORT_DEF && !def_en |=> !prog_mode && !nvm_active)
        else $error("mode held after program enable fell");

    lv_gate_a: assert property (
        @(posedge clk) disable iff (!nrst)
        $rose(prog_mode) && !alt_port_active && !$past(def_hv)
        |-> $past(low_voltage_programming_option))
        else $error("low-voltage entry without option bit");

    cfg_alt_bit_a: assert property (
        @(posedge clk) disable iff (!nrst)
        alt_port_active |-> !cfg_port_bit_wr_allow && (nvm_bulk == keep_alt_port_bit))
        else $error("alternate bit not protected on dedicated port");
endmodule

`default_nettype wire

// File: src/spmc_pkg.sv
package spmc_pkg;
    // Clock and self-timed erase duration
    localparam int          CLK_PERIOD_NS  = 4;
    localparam int          BULK_ERASE_US  = 5000;
    localparam int          BULK_ERASE_CYC = (BULK_ERASE_US * 1000) / CLK_PERIOD_NS;
    localparam int          BULK_TMR_W     = 21;

    // Serial word framing: 4-bit command then 16-bit payload, LSB first
    localparam int          WORD_W    = 20;
    localparam logic [4:0]  LAST_BIT  = 5'h13;
    localparam logic [4:0]  HOLD_BIT  = 5'h03;
    localparam logic [3:0]  CMD_NOP   = 4'h0;
    localparam logic [3:0]  CMD_START = 4'hF;
    localparam int          FIFO_DEPTH = 4;

    // Program memory control register fields
    localparam int          CTL_PGM_SPACE = 7;
    localparam int          CTL_CFG_SPACE = 6;
    localparam int          CTL_ERASE_SEL = 4;
    localparam int          CTL_REFUSED   = 3;
    localparam int          CTL_MODIFY_EN = 2;
    localparam int          CTL_TRIGGER   = 1;
    localparam logic [7:0]  CTL_RESET     = 8'h00;

    // Boot region limits (byte addresses) and block geometry
    localparam logic [21:0] BOOT_LIM_1KW = 22'h000800;
    localparam logic [21:0] BOOT_LIM_2KW = 22'h001000;
    localparam logic [21:0] BOOT_LIM_4KW = 22'h002000;
    localparam int          BLOCK_SHIFT  = 14;
    localparam int          NUM_BLOCKS   = 6;

    // One received serial word
    typedef struct packed {
        logic [15:0] payload;
        logic [3:0]  cmd;
    } spmc_word_s;

    // Which program-enable pin owns the session
    typedef enum logic [1:0] {PORT_NONE, PORT_DEF, PORT_ALT} spmc_port_e;

    // Erase/write sequencer
    typedef enum logic [1:0] {SQ_IDLE, SQ_ARMED, SQ_HOLD, SQ_TIMED} spmc_seq_e;
endpackage

// File: verification/spmc_prog_model.sv
`timescale 1ns/1ps
`default_nettype none
module spmc_prog_model;
    logic en  = 1'b0; // Program enable, low until entry
    logic sck = 1'b0; // Link clock, still between frames
    logic sd  = 1'b0; // Data, parked low between frames
    // Clock and data low first, then enable
    task automatic enter();
        sck = 1'b0;
        sd = 1'b0;
        #100 en = 1'b1;
    endtask
    // LSB first; 4th clock may be stretched for array time
    // Data moves with the rise so it stays steady across the sampling fall
    task automatic word(input logic [19:0] w, input int hold);
        for (int i = 0; i < 20; i++) begin
            sck = 1'b1;
            sd = w[i];
            #40;
            if (i == 3) #(hold);
            sck = 1'b0;
            #40;
        end
        sd = 1'b0; // Low while a timed erase runs
    endtask
endmodule
`default_nettype wire

// File: verification/serial_program_mode_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module serial_program_mode_control_tb_top;
    logic clk = 1'b0, nrst = 1'b0, lvr = 1'b0, lvo = 1'b0, alt = 1'b0, bl = 1'b0;
    logic wen = 1'b0, bulk = 1'b0, wrdy = 1'b0, s_row = 1'b0, s_keep = 1'b0, s_done = 1'b0;
    logic [3:0] dio;
    logic [1:0] bsz = 2'h0;
    logic [5:0] blk = 6'h02;
    logic [21:0] tp = 22'h000000;
    logic [7:0] wd = 8'h00, rd;
    logic hiz, md, ap, allow, keep, act, ers, bk, done, rxr, wv;
    spmc_pkg::spmc_word_s wdat;
    int fails = 0, tests_run = 0;
    spmc_prog_model i_spmc_prog_model();
    spmc_prog_model i_spmc_prog_model_alt();
    spmc_top #(.BULK_CYC(50)) i_spmc_top (.clk(clk), .nrst(nrst),
        .master_clear_program_pin(i_spmc_prog_model.en),
        .alternate_program_enable_pin(i_spmc_prog_model_alt.en),
        .serial_prog_clock(i_spmc_prog_model.sck), .serial_prog_data_pin(i_spmc_prog_model.sd),
        .serial_prog_data_out(dio[0]), .serial_prog_data_oe(dio[1]),
        .alternate_serial_clock_pin(i_spmc_prog_model_alt.sck),
        .alternate_serial_data_pin(i_spmc_prog_model_alt.sd),
        .alternate_serial_data_out(dio[2]), .alternate_serial_data_oe(dio[3]),
        .low_voltage_request_pin(lvr), .low_voltage_programming_option(lvo),
        .alternate_port_enable(alt), .boot_region_size_field(bsz), .boot_protect(bl),
        .block_protect(blk), .table_pointer(tp), .ctl_wr_en(wen), .ctl_wr_data(wd),
        .ctl_rd_data(rd), .bulk_erase_req(bulk), .prog_mode(md), .unused_io_hiz(hiz),
        .alt_port_active(ap), .cfg_port_bit_wr_allow(allow), .keep_alt_port_bit(keep),
        .nvm_active(act), .nvm_erase(ers), .nvm_bulk(bk), .nvm_done(done),
        .serial_rx_ready(rxr), .word_valid(wv), .word_ready(wrdy), .word_data(wdat));
    // Sticky flags catch short events inside long frames
    always @(posedge clk) begin
        if (act && ers && !bk) s_row <= 1'b1;
        if (keep && bk) s_keep <= 1'b1;
        if (done) s_done <= 1'b1;
    end
    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] d);
        @(posedge clk) {wen, wd} <= {1'b1, d};
        @(posedge clk) wen <= 1'b0;
    endtask
    // Arm then trigger; refusal shows in the refused bit of the read-back register
    task automatic trig(input logic [7:0] d, input logic [21:0] a, input logic [1:0] s,
                        input logic r);
        @(posedge clk) {tp, bsz} <= {a, s};
        wr(d); // Region and modify enable set just before the trigger
        wr(d | 8'h02);
        cyc(2);
        check(rd[3:1], {r, d[2], !r});
        if (r) wr(8'h84);
    endtask
    task automatic s_regs();
        i_spmc_prog_model.enter();
        cyc(8);
        check({md, hiz, dio}, 6'h30);
        @(posedge clk) bl <= 1'b1;
        trig(8'h80, 22'h009000, 2'h0, 1'b1);
        trig(8'hC4, 22'h009000, 2'h0, 1'b1);
        trig(8'h84, 22'h0007FE, 2'h0, 1'b1);
        trig(8'h84, 22'h004000, 2'h0, 1'b1);
        trig(8'h84, 22'h000C00, 2'h1, 1'b1);
        trig(8'h84, 22'h001C00, 2'h2, 1'b1);
        trig(8'h94, 22'h000C00, 2'h0, 1'b0);
        i_spmc_prog_model.word(20'h0, 400);
        cyc(4);
        check({s_row, s_done, rd[1]}, 3'h6);
    endtask
    task automatic s_fifo();
        logic [19:0] exp [4] = '{20'h0, 20'h1234F, 20'h0, 20'h0};
        wr(8'h84);
        i_spmc_prog_model.word(20'h1234F, 0);
        cyc(4);
        check(rd[1], 1'b1);
        for (int i = 0; i < 3; i++) i_spmc_prog_model.word(i < 2 ? 20'h0 : 20'hABCD5, 0);
        cyc(4);
        check(rxr, 1'b0);
        for (int i = 0; i < 4; i++) begin
            check(wdat, exp[i]);
            @(posedge clk) wrdy <= 1'b1;
            @(posedge clk) wrdy <= 1'b0;
            cyc(1);
        end
        check(wv, 1'b0);
    endtask
    task automatic s_alt();
        i_spmc_prog_model.en = 1'b0;
        cyc(8);
        check(md, 1'b0);
        @(posedge clk) alt <= 1'b1; // Dedicated-port part only
        i_spmc_prog_model_alt.enter();
        i_spmc_prog_model.enter();
        cyc(8);
        check({md, ap, allow}, 3'b110);
        i_spmc_prog_model.en = 1'b0;
        @(posedge clk) bulk <= 1'b1;
        @(posedge clk) bulk <= 1'b0;
        i_spmc_prog_model_alt.word(20'h0, 0);
        check({s_keep, ap}, 2'b11);
        i_spmc_prog_model_alt.en = 1'b0;
        i_spmc_prog_model.enter();
        cyc(8);
        check({md, allow}, 2'b11);
    endtask
    task automatic s_lv();
        i_spmc_prog_model.en = 1'b0;
        @(posedge clk) lvr <= 1'b1;
        cyc(8);
        check(md, 1'b0);
        @(posedge clk) {lvr, lvo} <= 2'h1;
        @(posedge clk) lvr <= 1'b1;
        cyc(8);
        check(md, 1'b1);
    endtask
    initial forever #2 clk = ~clk;
    initial begin
        #300000 fails++;
        end_of_test();
    end
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        cyc(2);
        s_regs();
        s_fifo();
        s_alt();
        s_lv();
        end_of_test();
    end
endmodule
`default_nettype wire
